// *** shared/pin_mux_pkg.sv ***
// Package with function codes, line indices and carrier types for the pin mux
package pin_mux_pkg;

  localparam int          LINE_FIRST    = 19;
  localparam int          LINE_COUNT    = 9;
  localparam int          ENTRY_FIRST   = 20;
  localparam int          FS_W          = 6;

  localparam logic [5:0]  FS_DISCONNECT = 6'h00;
  localparam logic [5:0]  FS_GPIO       = 6'h01;
  localparam logic [5:0]  FS_CODE2      = 6'h02;
  localparam logic [5:0]  FS_CODE3      = 6'h03;
  localparam logic [5:0]  FS_CODE4      = 6'h04;
  localparam logic [5:0]  FS_CODE5      = 6'h05;
  localparam logic [5:0]  FS_CODE6      = 6'h06;

  localparam logic [5:0]  FS_RESET      = 6'h00;
  localparam logic        CE_RESET      = 1'b0;
  localparam logic        INV_RESET     = 1'b0;
  localparam logic        PULL_RESET    = 1'b0;
  localparam logic        DRIVE_RESET   = 1'b0;

  // Wake-capable lines of the whole port (lines 0, 1, 17 and 18)
  localparam logic [27:0] WAKE_LINES    = 28'h0060003;
  // Line 19 is high-speed, the rest of this group are standard
  localparam logic [8:0]  HS_LINES      = 9'h001;

  // Pin-control entry for one line
  typedef struct packed {
    logic [5:0] function_select;
    logic       connect_enable;
    logic       invert;
    logic       pullup_req;
    logic       pulldown_req;
    logic       drive_high;
  } pin_control_entry_t;

  // Peripheral outputs toward the pads (value and enable)
  typedef struct packed {
    logic swd_data_out;
    logic swd_data_oe;
    logic spi_periph_out;
    logic spi_periph_out_oe;
    logic spi_periph_in;
    logic spi_periph_in_oe;
    logic spi_chip_select_2;
    logic spi_chip_select_3;
    logic timer0_channel0;
    logic timer0_channel1;
    logic timer1_channel0;
    logic timer1_channel1;
    logic timer2_channel0;
    logic timer2_channel1;
    logic timer4_channel0;
    logic timer4_channel1;
    logic [9:0] timer_oe;
    logic serial0_transmit;
    logic serial0_request_to_send;
    logic serial1_transmit;
    logic clock_output;
    logic [3:0] gpio_out;
  } periph_out_t;

  // Pad values delivered to peripheral inputs
  typedef struct packed {
    logic       swd_data_in;
    logic       swd_clock_in;
    logic       spi_periph_out_in;
    logic       spi_periph_in_in;
    logic       spi_chip_select_2_in;
    logic       spi_chip_select_3_in;
    logic [9:0] timer_in;
    logic       serial0_receive;
    logic       serial0_clear_to_send;
    logic       serial1_receive;
  } periph_in_t;

  typedef struct packed {
    logic [8:0] pad_out;
    logic [8:0] pad_oe;
    logic [8:0] pad_pullup;
    logic [8:0] pad_pulldown;
    logic [8:0] pad_drive_high;
    logic [8:0] gpio_in;
    periph_in_t periph_in;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       reset_pad_seen;
  } mux_state_t;

  // Timer bit order in timer_oe / timer_in
  localparam int T0C0 = 0;
  localparam int T0C1 = 1;
  localparam int T1C0 = 2;
  localparam int T1C1 = 3;
  localparam int T2C0 = 4;
  localparam int T2C1 = 5;
  localparam int T4C0 = 6;
  localparam int T4C1 = 7;

endpackage

// *** src/port_pin_function_mux.sv ***
// Pin-function multiplexer for port lines 19 to 27
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_mux (
  // Clock and reset
  input  wire logic                              CLK_SYS,
  input  wire logic                              RST_N,
  // Pin-control entries 20 to 28
  input  wire pin_mux_pkg::pin_control_entry_t [8:0] PIN_CONTROL_ENTRY,
  // Peripheral side
  input  wire pin_mux_pkg::periph_out_t          PERIPH_OUT,
  output var  pin_mux_pkg::periph_in_t           PERIPH_IN,
  output var  logic [8:0]                        GPIO_IN,
  // Pad side
  input  wire logic [8:0]                        PAD_IN,
  output var  logic [8:0]                        PAD_OUT,
  output var  logic [8:0]                        PAD_OE,
  output var  logic [8:0]                        PAD_PULLUP,
  output var  logic [8:0]                        PAD_PULLDOWN,
  output var  logic [8:0]                        PAD_DRIVE_HIGH,
  // Wake path and shared reset pad
  input  wire logic [27:0]                       WAKE_REQ,
  input  wire logic                              RESET_PAD_IN,
  output var  logic                              WAKE_OUT,
  output var  logic                              RESET_PAD_SEEN
);
  import pin_mux_pkg::*;

  mux_state_t  state_q;
  mux_state_t  state_d;
  logic [8:0]  pad_s1_q;
  logic [8:0]  pad_s2_q;
  logic [8:0]  pad_s3_q;
  logic [8:0]  pad_clean_q;
  logic        wake_q;
  logic [2:0]  rst_sync_q;
  logic [27:0] wake_s1_q;
  logic [27:0] wake_s2_q;
  logic [27:0] wake_s3_q;
  logic [27:0] wake_clean_q;

  // Pad input seen by the line: inverted when asked, zero when analog
  function automatic logic pad_view(input pin_control_entry_t e,
                                    input logic v);
    pad_view = e.connect_enable & (v ^ e.invert);
  endfunction

  function automatic logic sel(input pin_control_entry_t e,
                               input logic [5:0] code);
    sel = e.connect_enable && (e.function_select == code);
  endfunction

  // Input filter: a change counts once stages two and three agree
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pad_s1_q    <= 9'h000;
      pad_s2_q    <= 9'h000;
      pad_s3_q    <= 9'h000;
      pad_clean_q <= 9'h000;
      rst_sync_q  <= 3'h0;
    end else begin
      pad_s1_q   <= PAD_IN;
      pad_s2_q   <= pad_s1_q;
      pad_s3_q   <= pad_s2_q;
      rst_sync_q <= {rst_sync_q[1:0], RESET_PAD_IN};
      for (int i = 0; i < LINE_COUNT; i++) begin
        if (pad_s2_q[i] == pad_s3_q[i]) begin
          pad_clean_q[i] <= pad_s3_q[i];
        end
      end
    end
  end

  // Wake requests come from pads, so they pass the same three-stage filter
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wake_s1_q    <= 28'h0000000;
      wake_s2_q    <= 28'h0000000;
      wake_s3_q    <= 28'h0000000;
      wake_clean_q <= 28'h0000000;
      wake_q       <= 1'b0;
    end else begin
      wake_s1_q <= WAKE_REQ & WAKE_LINES;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      for (int i = 0; i < 28; i++) begin
        if (wake_s2_q[i] == wake_s3_q[i]) begin
          wake_clean_q[i] <= wake_s3_q[i];
        end
      end
      wake_q <= |wake_clean_q;
    end
  end

  always_comb begin
    pin_control_entry_t e;
    logic [8:0] v;
    logic [9:0] tin;
    e         = '0;
    tin       = 10'h000;
    v         = 9'h000;
    state_d   = state_q;
    // inactive defaults: idle-high serial receive and select inputs, clear-to-send low
    state_d.periph_in = '0;
    state_d.periph_in.serial0_receive       = 1'b1;
    state_d.periph_in.serial1_receive       = 1'b1;
    state_d.periph_in.serial0_clear_to_send = 1'b0;
    state_d.periph_in.spi_chip_select_2_in  = 1'b1;
    state_d.periph_in.spi_chip_select_3_in  = 1'b1;
    state_d.pad_out        = 9'h000;
    state_d.pad_oe         = 9'h000;
    state_d.gpio_in        = 9'h000;
    for (int i = 0; i < LINE_COUNT; i++) begin
      e = PIN_CONTROL_ENTRY[i];
      v[i] = pad_view(e, pad_clean_q[i]);
      state_d.pad_pulldown[i]   = e.connect_enable & e.pulldown_req;
      state_d.pad_pullup[i]     = e.connect_enable & e.pullup_req;
      state_d.pad_drive_high[i] = e.connect_enable & e.drive_high
                                  & HS_LINES[i];
      if (sel(e, FS_GPIO)) begin
        state_d.gpio_in[i] = v[i];
        state_d.pad_out[i] = PERIPH_OUT.gpio_out[i % 4] ^ e.invert;
      end
    end
    // Per-line decode; where two lines feed one input the higher line wins
    // Line 19
    e = PIN_CONTROL_ENTRY[0];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[0] = PERIPH_OUT.swd_data_out ^ e.invert;
      state_d.pad_oe[0]  = PERIPH_OUT.swd_data_oe;
      state_d.periph_in.swd_data_in = v[0];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[0] = PERIPH_OUT.spi_periph_out ^ e.invert;
      state_d.pad_oe[0]  = PERIPH_OUT.spi_periph_out_oe;
      state_d.periph_in.spi_periph_out_in = v[0];
    end
    // Line 20
    e = PIN_CONTROL_ENTRY[1];
    if (sel(e, FS_CODE2)) begin
      state_d.periph_in.swd_clock_in = v[1];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[1] = PERIPH_OUT.timer4_channel0 ^ e.invert;
      state_d.pad_oe[1]  = PERIPH_OUT.timer_oe[T4C0];
      tin[T4C0] = v[1];
    end
    // Line 21
    e = PIN_CONTROL_ENTRY[2];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[2] = PERIPH_OUT.timer2_channel0 ^ e.invert;
      state_d.pad_oe[2]  = PERIPH_OUT.timer_oe[T2C0];
      tin[T2C0] = v[2];
    end else if (sel(e, FS_CODE3)) begin
      state_d.periph_in.serial0_clear_to_send = v[2];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[2] = PERIPH_OUT.serial0_transmit ^ e.invert;
      state_d.pad_oe[2]  = 1'b1;
    end
    // Line 22
    e = PIN_CONTROL_ENTRY[3];
    if (sel(e, FS_CODE2)) begin
      state_d.periph_in.serial0_receive = v[3];
    end else if (sel(e, FS_CODE3)) begin
      state_d.pad_out[3] = PERIPH_OUT.timer2_channel1 ^ e.invert;
      state_d.pad_oe[3]  = PERIPH_OUT.timer_oe[T2C1];
      tin[T2C1] = v[3];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[3] = PERIPH_OUT.serial0_request_to_send ^ e.invert;
      state_d.pad_oe[3]  = 1'b1;
    end else if (sel(e, FS_CODE5)) begin
      state_d.pad_out[3] = PERIPH_OUT.clock_output ^ e.invert;
      state_d.pad_oe[3]  = 1'b1;
    end else if (sel(e, FS_CODE6)) begin
      state_d.periph_in.serial1_receive = v[3];
    end
    // Line 23
    e = PIN_CONTROL_ENTRY[4];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[4] = PERIPH_OUT.serial0_transmit ^ e.invert;
      state_d.pad_oe[4]  = 1'b1;
    end else if (sel(e, FS_CODE3)) begin
      state_d.pad_out[4] = PERIPH_OUT.spi_chip_select_3 ^ e.invert;
      state_d.pad_oe[4]  = 1'b1;
      state_d.periph_in.spi_chip_select_3_in = v[4];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[4] = PERIPH_OUT.timer0_channel0 ^ e.invert;
      state_d.pad_oe[4]  = PERIPH_OUT.timer_oe[T0C0];
      tin[T0C0] = v[4];
    end else if (sel(e, FS_CODE5)) begin
      state_d.periph_in.serial0_clear_to_send = v[4];
    end else if (sel(e, FS_CODE6)) begin
      state_d.pad_out[4] = PERIPH_OUT.serial1_transmit ^ e.invert;
      state_d.pad_oe[4]  = 1'b1;
    end
    // Line 24
    e = PIN_CONTROL_ENTRY[5];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[5] = PERIPH_OUT.spi_chip_select_2 ^ e.invert;
      state_d.pad_oe[5]  = 1'b1;
      state_d.periph_in.spi_chip_select_2_in = v[5];
    end else if (sel(e, FS_CODE3)) begin
      state_d.pad_out[5] = PERIPH_OUT.timer0_channel1 ^ e.invert;
      state_d.pad_oe[5]  = PERIPH_OUT.timer_oe[T0C1];
      tin[T0C1] = v[5];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[5] = PERIPH_OUT.serial0_request_to_send ^ e.invert;
      state_d.pad_oe[5]  = 1'b1;
    end
    // Line 25
    e = PIN_CONTROL_ENTRY[6];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[6] = PERIPH_OUT.timer4_channel1 ^ e.invert;
      state_d.pad_oe[6]  = PERIPH_OUT.timer_oe[T4C1];
      tin[T4C1] = v[6];
    end else if (sel(e, FS_CODE3)) begin
      state_d.pad_out[6] = PERIPH_OUT.serial0_transmit ^ e.invert;
      state_d.pad_oe[6]  = 1'b1;
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[6] = PERIPH_OUT.spi_periph_in ^ e.invert;
      state_d.pad_oe[6]  = PERIPH_OUT.spi_periph_in_oe;
      state_d.periph_in.spi_periph_in_in = v[6];
    end
    // Line 26
    e = PIN_CONTROL_ENTRY[7];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[7] = PERIPH_OUT.timer1_channel0 ^ e.invert;
      state_d.pad_oe[7]  = PERIPH_OUT.timer_oe[T1C0];
      tin[T1C0] = v[7];
    end else if (sel(e, FS_CODE3)) begin
      state_d.periph_in.serial0_receive = v[7];
    end else if (sel(e, FS_CODE4)) begin
      state_d.pad_out[7] = PERIPH_OUT.spi_periph_out ^ e.invert;
      state_d.pad_oe[7]  = PERIPH_OUT.spi_periph_out_oe;
      state_d.periph_in.spi_periph_out_in = v[7];
    end
    // Line 27
    e = PIN_CONTROL_ENTRY[8];
    if (sel(e, FS_CODE2)) begin
      state_d.pad_out[8] = PERIPH_OUT.timer1_channel1 ^ e.invert;
      state_d.pad_oe[8]  = PERIPH_OUT.timer_oe[T1C1];
      tin[T1C1] = v[8];
    end else if (sel(e, FS_CODE3)) begin
      state_d.pad_out[8] = PERIPH_OUT.spi_chip_select_3 ^ e.invert;
      state_d.pad_oe[8]  = 1'b1;
      state_d.periph_in.spi_chip_select_3_in = v[8];
    end
    state_d.periph_in.timer_in = tin;
    // analog lines (code 0, connect 0) never drive
    for (int i = 0; i < LINE_COUNT; i++) begin
      if (!PIN_CONTROL_ENTRY[i].connect_enable) begin
        state_d.pad_oe[i]  = 1'b0;
        state_d.pad_out[i] = 1'b0;
      end
    end
    state_d.sync_a = 3'h0;
    state_d.sync_b = 3'h0;
    // shared reset pad, low holds reset; a change counts once
    // the second and third stages agree, otherwise the old view holds
    if (rst_sync_q[1] == rst_sync_q[2]) begin
      state_d.reset_pad_seen = ~rst_sync_q[2];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= '0;
      state_q.periph_in.serial0_receive      <= 1'b1;
      state_q.periph_in.serial1_receive      <= 1'b1;
      state_q.periph_in.spi_chip_select_2_in <= 1'b1;
      state_q.periph_in.spi_chip_select_3_in <= 1'b1;
      state_q.reset_pad_seen                 <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign PERIPH_IN      = state_q.periph_in;
  assign GPIO_IN        = state_q.gpio_in;
  assign PAD_OUT        = state_q.pad_out;
  assign PAD_OE         = state_q.pad_oe;
  assign PAD_PULLUP     = state_q.pad_pullup;
  assign PAD_PULLDOWN   = state_q.pad_pulldown;
  assign PAD_DRIVE_HIGH = state_q.pad_drive_high;
  assign WAKE_OUT       = wake_q;
  assign RESET_PAD_SEEN = state_q.reset_pad_seen;
endmodule
`default_nettype wire

// *** test/pad_model.sv ***
// Board-side model of the nine pads: drive, pulls and floating lines
`timescale 1ns/10ps
`default_nettype none
module pad_model (
  // Device side
  input  wire logic       clk,
  input  wire logic [8:0] pad_out,
  input  wire logic [8:0] pad_oe,
  input  wire logic [8:0] pad_pu,
  input  wire logic [8:0] pad_pd,
  // Board side
  input  wire logic [8:0] ext_val,
  input  wire logic [8:0] ext_oe,
  output var  logic [8:0] pad_in
);
  logic tgl = 1'b0;
  // A pad nobody holds wanders, so a stale value never looks valid
  always @(negedge clk) begin
    tgl <= ~tgl;
  end
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_oe[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pu[i]) begin
        pad_in[i] = 1'b1;
      end else if (pad_pd[i]) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = tgl ^ i[0];
      end
    end
  end
endmodule
`default_nettype wire

// *** test/pin_mux_assertions.sv ***
// Port assertions for the pin-function multiplexer
`timescale 1ns/10ps
`default_nettype none
module pin_mux_checker (
  // Clock and reset
  input wire logic                                  CLK_SYS,
  input wire logic                                  RST_N,
  // Configuration and peripherals
  input wire pin_mux_pkg::pin_control_entry_t [8:0] PIN_CONTROL_ENTRY,
  input wire pin_mux_pkg::periph_out_t              PERIPH_OUT,
  input wire pin_mux_pkg::periph_in_t               PERIPH_IN,
  input wire logic [8:0]                            GPIO_IN,
  // Pads
  input wire logic [8:0]                            PAD_IN,
  input wire logic [8:0]                            PAD_OUT,
  input wire logic [8:0]                            PAD_OE,
  input wire logic [8:0]                            PAD_PULLUP,
  input wire logic [8:0]                            PAD_PULLDOWN,
  // Wake and shared reset pad
  input wire logic [27:0]                           WAKE_REQ,
  input wire logic                                  RESET_PAD_IN,
  input wire logic                                  WAKE_OUT,
  input wire logic                                  RESET_PAD_SEEN
);
  import pin_mux_pkg::*;
  logic [8:0] ce_vec;
  logic [8:0] odd_code;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      ce_vec[i]   = PIN_CONTROL_ENTRY[i].connect_enable;
      odd_code[i] = PIN_CONTROL_ENTRY[i].function_select > 6'h06;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence swd_clk_held;
    PIN_CONTROL_ENTRY[1].function_select == 6'h02 &&
      PIN_CONTROL_ENTRY[1].connect_enable &&
      !PIN_CONTROL_ENTRY[1].invert && $stable(PAD_IN[1]);
  endsequence
  sequence gpio0_held;
    PIN_CONTROL_ENTRY[0].function_select == 6'h01 &&
      PIN_CONTROL_ENTRY[0].connect_enable &&
      !PIN_CONTROL_ENTRY[0].invert && $stable(PAD_IN[0]);
  endsequence
  sequence clk_out_sel;
    PIN_CONTROL_ENTRY[3].function_select == 6'h05 &&
      PIN_CONTROL_ENTRY[3].connect_enable && !PIN_CONTROL_ENTRY[3].invert;
  endsequence
  sequence wake_held;
    $stable(WAKE_REQ & 28'h0060003);
  endsequence
  wake_map_a: assert property (wake_held [*5] |->
    WAKE_OUT == ((WAKE_REQ & 28'h0060003) != 28'h0000000))
    else $error("wake output not the OR of the wake lines");
  analog_off_a: assert property (1'b1 |=>
    ((PAD_OE | PAD_PULLUP | PAD_PULLDOWN) & ~$past(ce_vec)) == 9'h000)
    else $error("pad active with connect off");
  odd_code_a: assert property (1'b1 |=>
    (PAD_OE & $past(odd_code)) == 9'h000)
    else $error("pad driven for an unassigned code");
  clk_out_a: assert property (clk_out_sel |=> PAD_OE[3] &&
    PAD_OUT[3] == $past(PERIPH_OUT.clock_output))
    else $error("clock output not on line 22");
  swd_clk_a: assert property (swd_clk_held [*7] |->
    PERIPH_IN.swd_clock_in == PAD_IN[1])
    else $error("debug clock input not following line 20");
  gpio_in_a: assert property (gpio0_held [*7] |->
    GPIO_IN[0] == PAD_IN[0])
    else $error("general input not following line 19");
  seen_low_a: assert property (!RESET_PAD_IN [*4] |->
    ##[0:3] RESET_PAD_SEEN)
    else $error("low reset pad not seen");
  seen_high_a: assert property (RESET_PAD_IN [*4] |->
    ##[0:3] !RESET_PAD_SEEN)
    else $error("high reset pad still seen");
  pull_pass_a: assert property (PIN_CONTROL_ENTRY[2] == 11'h034 |=>
    PAD_PULLUP[2] && !PAD_OE[2])
    else $error("pullup request lost on line 21");
endmodule
bind port_pin_function_mux pin_mux_checker i_chk (
  .CLK_SYS, .RST_N, .PIN_CONTROL_ENTRY, .PERIPH_OUT, .PERIPH_IN, .GPIO_IN,
  .PAD_IN, .PAD_OUT, .PAD_OE, .PAD_PULLUP, .PAD_PULLDOWN, .WAKE_REQ,
  .RESET_PAD_IN, .WAKE_OUT, .RESET_PAD_SEEN
);
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the pin-function multiplexer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pin_mux_pkg::*;
  typedef struct {int ln; logic [5:0] code; int sig;} row_t;
  logic                     clk_sys = 1'b0;
  logic                     rst_n   = 1'b0;
  pin_control_entry_t [8:0] ent     = '0;
  periph_out_t              po      = '0;
  periph_in_t               p_in;
  logic [8:0]               gpio_in, pad_in, pad_out, pad_oe;
  logic [8:0]               pad_pu, pad_pd, pad_dh;
  logic [8:0]               ext_val = '0;
  logic [8:0]               ext_oe  = '0;
  logic [27:0]              wake_req = '0;
  logic                     reset_pad = 1'b1;
  logic                     wake_out, seen;
  int                       err_count = 0;
  int                       cmp_count = 0;
  // Line index, function code, peripheral output expected on the pad
  row_t rows [22] = '{'{0,6'h2,0}, '{0,6'h4,1}, '{1,6'h4,11},
    '{2,6'h2,9}, '{2,6'h4,13}, '{3,6'h3,10}, '{3,6'h4,14},
    '{3,6'h5,16}, '{4,6'h2,13}, '{4,6'h3,4}, '{4,6'h4,5},
    '{4,6'h6,15}, '{5,6'h2,3}, '{5,6'h3,6}, '{5,6'h4,14},
    '{6,6'h2,12}, '{6,6'h3,13}, '{6,6'h4,2}, '{7,6'h2,7},
    '{7,6'h4,1}, '{8,6'h2,8}, '{8,6'h3,4}};
  port_pin_function_mux i_dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PIN_CONTROL_ENTRY(ent),
    .PERIPH_OUT(po), .PERIPH_IN(p_in), .GPIO_IN(gpio_in), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu),
    .PAD_PULLDOWN(pad_pd), .PAD_DRIVE_HIGH(pad_dh), .WAKE_REQ(wake_req),
    .RESET_PAD_IN(reset_pad), .WAKE_OUT(wake_out), .RESET_PAD_SEEN(seen));
  pad_model i_pad (.clk(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .ext_val(ext_val), .ext_oe(ext_oe),
    .pad_in(pad_in));
  // All enables on, every output the opposite of the one under test
  function automatic periph_out_t drive(int s, logic v);
    periph_out_t p;
    p = v ? '0 : '1;
    p.swd_data_oe = 1'b1;
    p.spi_periph_out_oe = 1'b1;
    p.spi_periph_in_oe = 1'b1;
    p.timer_oe = '1;
    case (s)
      0: p.swd_data_out = v;
      1: p.spi_periph_out = v;
      2: p.spi_periph_in = v;
      3: p.spi_chip_select_2 = v;
      4: p.spi_chip_select_3 = v;
      5: p.timer0_channel0 = v;
      6: p.timer0_channel1 = v;
      7: p.timer1_channel0 = v;
      8: p.timer1_channel1 = v;
      9: p.timer2_channel0 = v;
      10: p.timer2_channel1 = v;
      11: p.timer4_channel0 = v;
      12: p.timer4_channel1 = v;
      13: p.serial0_transmit = v;
      14: p.serial0_request_to_send = v;
      15: p.serial1_transmit = v;
      default: p.clock_output = v;
    endcase
    return p;
  endfunction
  task automatic check(logic [27:0] got, logic [27:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cfg(int ln, logic [5:0] code, logic ce, logic [2:0] x);
    pin_control_entry_t [8:0] e;
    e = '0;
    e[ln] = {code, ce, 1'b0, x};
    @(negedge clk_sys);
    ent = e;
    @(negedge clk_sys);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    check(pad_oe, 9'h000);
    check(seen, 1'b1);
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int r = 0; r < 22; r++) begin
      for (int v = 0; v < 2; v++) begin
        po = drive(rows[r].sig, v[0]);
        cfg(rows[r].ln, rows[r].code, 1'b1, 3'h0);
        check(pad_oe, 9'h001 << rows[r].ln);
        check(pad_out[rows[r].ln], v[0]);
      end
    end
    for (int b = 0; b < 28; b++) begin
      wake_req = 28'h0000001 << b;
      repeat (6) @(negedge clk_sys);
      check(wake_out, b == 0 || b == 1 || b == 17 || b == 18);
    end
    wake_req = '0;
    po = drive(0, 1'b1);
    cfg(1, 6'h3, 1'b1, 3'h0);
    check(pad_oe, 9'h000);
    repeat (6) @(negedge clk_sys);
    check(p_in.serial0_receive, 1'b1);
    check(p_in.swd_clock_in, 1'b0);
    cfg(8, 6'h4, 1'b1, 3'h0);
    check(pad_oe, 9'h000);
    cfg(4, 6'h3F, 1'b1, 3'h0);
    check(pad_oe, 9'h000);
    cfg(0, 6'h2, 1'b0, 3'h4);
    check(pad_oe | pad_pu, 9'h000);
    cfg(2, 6'h1, 1'b1, 3'h4);
    check(pad_pu, 9'h004);
    cfg(5, 6'h1, 1'b1, 3'h2);
    check(pad_pd, 9'h020);
    cfg(0, 6'h1, 1'b1, 3'h1);
    check(pad_dh, 9'h001);
    cfg(1, 6'h1, 1'b1, 3'h1);
    check(pad_dh, 9'h000);
    ext_oe = '1;
    for (int v = 0; v < 2; v++) begin
      ext_val = {9{v[0]}};
      cfg(1, 6'h2, 1'b1, 3'h0);
      repeat (6) @(negedge clk_sys);
      check(p_in.swd_clock_in, v);
      cfg(0, 6'h1, 1'b1, 3'h0);
      repeat (6) @(negedge clk_sys);
      check(gpio_in, v);
      cfg(3, 6'h2, 1'b1, 3'h0);
      repeat (6) @(negedge clk_sys);
      check(p_in.serial0_receive, v);
      cfg(2, 6'h3, 1'b1, 3'h0);
      repeat (6) @(negedge clk_sys);
      check(p_in.serial0_clear_to_send, v);
    end
    ext_oe = '0;
    reset_pad = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(seen, 1'b1);
    reset_pad = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(seen, 1'b0);
    po = drive(16, 1'b1);
    cfg(3, 6'h5, 1'b1, 3'h0);
    check(pad_oe, 9'h008);
    rst_n = 1'b0;
    #1;
    check(pad_oe, 9'h000);
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(pad_oe, 9'h008);
    complete_run();
  end
endmodule
`default_nettype wire
